// *** shared/csisc_pkg.sv ***
// constants for the channel-0 start, status and transfer-end interrupt block
package csisc_pkg;
  localparam logic [7:0]  OFF_IRQ_REQ   = 8'h00;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h04;
  localparam logic [7:0]  OFF_START     = 8'h08;
  localparam logic [7:0]  OFF_STATUS    = 8'h0C;
  localparam logic [7:0]  OFF_DATA      = 8'h10;
  localparam logic [7:0]  OFF_MODE      = 8'h14;
  localparam logic [7:0]  OFF_STOP      = 8'h18;
  localparam int          BIT_XFER_END  = 5;
  localparam int          BIT_START0    = 0;
  localparam int          BIT_ACTIVE    = 6;
  localparam int          BIT_BUF_FULL  = 5;
  localparam int          BIT_PARITY    = 1;
  localparam int          BIT_OVERRUN   = 0;
  localparam logic [1:0]  LEN_7BIT      = 2'h2;
  localparam logic [1:0]  LEN_8BIT      = 2'h3;
  localparam logic [7:0]  RST_IRQ_REQ   = 8'h00;
  localparam logic [7:0]  RST_IRQ_MASK  = 8'hFF;
  localparam logic [1:0]  RST_MODE      = 2'h3;
  localparam int          CLK_DIV_HALF  = 4;
endpackage

// *** rtl/csisc_shifter.sv ***
// serial shifter: clock generation, transmit and receive of one frame
`timescale 1ns/1ps
`default_nettype none
module csisc_shifter
  import csisc_pkg::*;
#(
  parameter int HALF = CLK_DIV_HALF
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  input  wire logic [3:0] nbits,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rx_byte,
  // serial pins (rx already synchronised)
  output logic            sck,
  output logic            sdo,
  input  wire logic       sdi
);
  logic [7:0] sh;
  logic [7:0] cnt_div;
  logic [3:0] left;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      sh <= 8'h00;
      cnt_div <= 8'h00;
      left <= 4'h0;
      sck <= 1'b1;
      sdo <= 1'b1;
      rx_byte <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        // msb first, 7-bit frames left-justified
        sh <= (nbits == 4'h7) ? {tx_byte[6:0], 1'b0} : tx_byte;
        sdo <= (nbits == 4'h7) ? tx_byte[6] : tx_byte[7];
        left <= nbits;
        cnt_div <= 8'h00;
      end else if (busy) begin
        if (cnt_div == 8'(HALF - 1)) begin
          cnt_div <= 8'h00;
          sck <= ~sck;
          if (sck) begin
            // drive on falling so the bit stands a full half period before the rising sample
            sdo <= sh[7];
            sh  <= {sh[6:0], 1'b0};
          end else begin
            rx_byte <= {rx_byte[6:0], sdi};
            left <= left - 4'h1;
            if (left == 4'h1) begin
              busy <= 1'b0;
              done <= 1'b1;
            end
          end
        end else begin
          cnt_div <= cnt_div + 8'h01;
        end
      end
    end
  end
endmodule // csisc_shifter
`default_nettype wire

// *** rtl/csisc_top.sv ***
// apb register file, channel start and status, transfer-end interrupt
`timescale 1ns/1ps
`default_nettype none
module csisc_top
  import csisc_pkg::*;
#(
  parameter int HALF = CLK_DIV_HALF
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // interrupt
  output logic             irq,
  // serial pins
  output logic             sck,
  output logic             sdo,
  input  wire logic        sdi
);
  logic [7:0] irq_request_flags_high;
  logic [7:0] irq_mask_flags_high;
  logic       chan0_enabled_status;
  logic       transfer_active_flag;
  logic       buf_full;
  logic       overrun_err;
  logic [7:0] chan0_byte_data;
  logic [1:0] length_sel;
  logic       sdi_m;
  logic       sdi_s;
  logic       busy;
  logic       done;
  logic [7:0] rx_byte;
  logic       wr;
  logic       rd;
  logic       mapped;
  logic       launch;
  logic       len_ok;

  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign mapped  = paddr inside {OFF_IRQ_REQ, OFF_IRQ_MASK, OFF_START, OFF_STATUS,
                                 OFF_DATA, OFF_MODE, OFF_STOP};
  assign pslverr = psel && penable && !mapped;
  assign len_ok  = (length_sel == LEN_7BIT) || (length_sel == LEN_8BIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdi_m <= 1'b1;
      sdi_s <= 1'b1;
    end else begin
      sdi_m <= sdi;
      sdi_s <= sdi_m;
    end
  end

  assign launch = wr && paddr == OFF_DATA && chan0_enabled_status && !transfer_active_flag && len_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      chan0_enabled_status <= 1'b0;
    else if (wr && paddr == OFF_START && pwdata[BIT_START0])
      chan0_enabled_status <= 1'b1;
    else if (wr && paddr == OFF_STOP && pwdata[BIT_START0])
      chan0_enabled_status <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      transfer_active_flag <= 1'b0;
    else if (launch)
      transfer_active_flag <= 1'b1;
    else if (done)
      transfer_active_flag <= 1'b0;
  end

  // low byte of a data write stored; the received byte replaces it at transfer end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan0_byte_data <= 8'h00;
      buf_full <= 1'b0;
      length_sel <= RST_MODE;
    end else begin
      if (wr && paddr == OFF_DATA)
        chan0_byte_data <= pwdata[7:0];
      else if (done)
        chan0_byte_data <= rx_byte;
      if (done)
        buf_full <= 1'b1;
      else if (rd && paddr == OFF_DATA)
        buf_full <= 1'b0;
      if (wr && paddr == OFF_MODE)
        length_sel <= pwdata[1:0];
    end
  end

  // overrun error, cleared by writing one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      overrun_err <= 1'b0;
    else if (done && buf_full && !(rd && paddr == OFF_DATA))
      overrun_err <= 1'b1;
    else if (wr && paddr == OFF_STATUS && pwdata[BIT_OVERRUN])
      overrun_err <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_request_flags_high <= RST_IRQ_REQ;
    else begin
      if (wr && paddr == OFF_IRQ_REQ)
        // writing 0 clears; writing 1 leaves the flag as it is
        irq_request_flags_high[BIT_XFER_END] <= pwdata[BIT_XFER_END] &&
                                                irq_request_flags_high[BIT_XFER_END];
      if (done)
        irq_request_flags_high[BIT_XFER_END] <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_mask_flags_high <= RST_IRQ_MASK;
    else if (wr && paddr == OFF_IRQ_MASK)
      irq_mask_flags_high <= pwdata[7:0];
  end

  assign irq = irq_request_flags_high[BIT_XFER_END] && !irq_mask_flags_high[BIT_XFER_END];

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        OFF_IRQ_REQ:  prdata[7:0] = irq_request_flags_high & 8'h20;
        OFF_IRQ_MASK: prdata[7:0] = irq_mask_flags_high;
        OFF_STATUS: begin
          prdata[BIT_ACTIVE]   = transfer_active_flag;
          prdata[BIT_BUF_FULL] = buf_full;
          prdata[BIT_OVERRUN]  = overrun_err;
        end
        OFF_DATA:     prdata[7:0] = chan0_byte_data;
        OFF_MODE: begin
          prdata[1:0] = length_sel;
          prdata[8]   = chan0_enabled_status;
        end
        default:      prdata = 32'h0000_0000;
      endcase
    end
  end

  csisc_shifter #(.HALF(HALF)) u_shift (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (launch),
    .tx_byte (pwdata[7:0]),
    .nbits   ((length_sel == LEN_7BIT) ? 4'h7 : 4'h8),
    .busy    (busy),
    .done    (done),
    .rx_byte (rx_byte),
    .sck     (sck),
    .sdo     (sdo),
    .sdi     (sdi_s)
  );

  xfer_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    done |=> irq_request_flags_high[BIT_XFER_END] && !transfer_active_flag)
    else $error("transfer end did not raise flag");
  start_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == OFF_START |-> prdata == 32'h0000_0000)
    else $error("start register read nonzero");
  active_launch_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch |=> transfer_active_flag)
    else $error("launch did not mark active");
  enable_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFF_START && pwdata[0] |=> chan0_enabled_status)
    else $error("start trigger did not enable");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_mask_flags_high[5] |-> !irq)
    else $error("masked interrupt asserted");
  active_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == OFF_STATUS |-> prdata[6] == transfer_active_flag)
    else $error("status bit 6 wrong");
  flag_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == OFF_IRQ_REQ |-> prdata[5] == irq_request_flags_high[5])
    else $error("flag bit 5 wrong");
  bad_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    !len_ok |-> !launch)
    else $error("prohibited length launched");
  overrun_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && buf_full && !rd |=> overrun_err)
    else $error("overrun not flagged");
  byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFF_DATA |=> chan0_byte_data == $past(pwdata[7:0]) || done)
    else $error("data byte not stored");
  busy_active_a: assert property (@(posedge pclk) disable iff (!presetn)
    busy |-> transfer_active_flag)
    else $error("shifter busy while status idle");
  cv_launch_c: cover property (@(posedge pclk) launch);
  cv_done_c:   cover property (@(posedge pclk) done);
  cv_irq_c:    cover property (@(posedge pclk) irq);
endmodule // csisc_top
`default_nettype wire

// *** bench/csisc_peer.sv ***
// serial peer model: answers every frame msb first and captures what it hears
`timescale 1ns/1ps
`default_nettype none
module csisc_peer (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // serial pins
  input  wire logic       sck,
  input  wire logic       sdo,
  output logic            sdi,
  // frame setup and capture
  input  wire logic [3:0] nbits,
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      got
);
  logic       sck_d;
  logic       in_frame;
  logic [3:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d    <= 1'b1;
      in_frame <= 1'b0;
      cnt      <= 4'h0;
      sdi      <= 1'b0;
      got      <= 8'h00;
    end else begin
      sck_d <= sck;
      if (sck_d && !sck) begin
        in_frame <= 1'b1;
        sdi      <= tx_byte[nbits - 4'h1 - (in_frame ? cnt : 4'h0)];
        if (!in_frame)
          cnt <= 4'h0;
      end else if (!sck_d && sck && in_frame) begin
        got <= {got[6:0], sdo};
        cnt <= cnt + 4'h1;
        if (cnt + 4'h1 == nbits)
          in_frame <= 1'b0;
      end else if (!in_frame) begin
        // the line has no pull: keep it moving so a stale bit is never mistaken for data
        sdi <= ~sdi;
      end
    end
  end
endmodule // csisc_peer
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench: apb stimulus, read-result queue, serial peer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import csisc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, ptx = 8'h00, got;
  logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h5359;
  logic [3:0]  pnb = 4'h8;
  logic        pready, pslverr, irq, sck, sdo, sdi;
  logic [32:0] note_q[$], mask_q[$];
  logic [1:0]  modes[4] = '{2'h0, 2'h1, LEN_7BIT, LEN_8BIT};
  int          mismatches = 0, comparisons = 0, cycles = 0, k;
  always #25 pclk = ~pclk;
  csisc_top #(.HALF(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .irq(irq), .sck(sck), .sdo(sdo), .sdi(sdi));
  csisc_peer peer (.pclk(pclk), .presetn(presetn), .sck(sck), .sdo(sdo), .sdi(sdi),
    .nbits(pnb), .tx_byte(ptx), .got(got));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    note_q.push_back(e);
    mask_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  // the watcher takes the oldest note whenever a read completes
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && note_q.size() > 0) begin
      check({pslverr, prdata} & mask_q[0], note_q[0] & mask_q[0]);
      void'(note_q.pop_front());
      void'(mask_q.pop_front());
    end
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_IRQ_REQ, 33'h0, 33'h1_0000_0020);
    rd(OFF_IRQ_MASK, {25'h0, RST_IRQ_MASK}, 33'h1_0000_0020);
    rd(8'h3C, 33'h1_0000_0000, 33'h1_0000_0000);
    apb(1'b1, OFF_START, 32'h0000_FFFE);
    apb(1'b1, OFF_DATA, 32'h0000_0055);
    rd(OFF_STATUS, 33'h0, 33'h1_0000_0040);
    apb(1'b1, OFF_START, 32'h0000_0001);
    rd(OFF_START, 33'h0, 33'h1_FFFF_FFFF);
    // clear the request before unmasking, as software must
    apb(1'b1, OFF_IRQ_REQ, 32'h0);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_00DF);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      pnb <= (modes[i] == LEN_7BIT) ? 4'h7 : 4'h8;
      ptx <= seed[15:8];
      apb(1'b1, OFF_MODE, {30'h0, modes[i]});
      apb(1'b1, OFF_IRQ_REQ, 32'h0);
      apb(1'b1, OFF_DATA, seed);
      rd(OFF_STATUS, {26'h0, i > 1, 6'h0}, 33'h1_0000_0040);
      k = 0;
      do rd(OFF_STATUS, 33'h0, 33'h0); while (r[6] !== 1'b0 && k++ < 40);
      check(irq, i > 1);
      rd(OFF_IRQ_REQ, {27'h0, i > 1, 5'h0}, 33'h1_0000_0020);
      rd(OFF_STATUS, {27'h0, i > 1, 5'h0}, 33'h1_0000_0060);
      if (i > 1) begin
        rd(OFF_DATA, {25'h0, seed[15:8] & {pnb[3], 7'h7F}}, {1'b1, 24'h0, pnb[3], 7'h7F});
        check(got & (pnb[3] ? 8'hFF : 8'h7F), seed[7:0] & (pnb[3] ? 8'hFF : 8'h7F));
      end
    end
    // two frames with no data read between them: the second one overruns
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, OFF_DATA, 32'h0000_00A5);
      k = 0;
      do rd(OFF_STATUS, 33'h0, 33'h0); while (r[6] !== 1'b0 && k++ < 40);
    end
    rd(OFF_STATUS, 33'h21, 33'h1_0000_0021);
    apb(1'b1, OFF_STATUS, 32'h0000_0001);
    rd(OFF_STATUS, 33'h20, 33'h1_0000_0021);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_00FF);
    check(irq, 1'b0);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_00DF);
    check(irq, 1'b1);
    apb(1'b1, OFF_IRQ_REQ, 32'h0);
    check(irq, 1'b0);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
